// ### adccc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 25 MHz system clock, 1.024 MHz internal oscillator emulated
// Notes:   byte offsets of 32-bit words on the register bus
package adccc_pkg;
    // clock rates
    localparam int unsigned SYS_CLK_HZ      = 25_000_000;
    localparam int unsigned OSC_HZ          = 1_024_000;
    localparam int unsigned MOD_DIV         = 4;
    // register byte offsets
    localparam logic [4:0]  OFS_CONFIG      = 5'h00;
    localparam logic [4:0]  OFS_COMMAND     = 5'h04;
    localparam logic [4:0]  OFS_STATUS      = 5'h08;
    localparam logic [4:0]  OFS_RESULT      = 5'h0C;
    localparam logic [4:0]  OFS_HOST_DATA   = 5'h10;
    // config field positions
    localparam int          CFG_MUX_LSB     = 5;
    localparam int          CFG_GAIN_BIT    = 4;
    localparam int          CFG_RATE_LSB    = 2;
    localparam int          CFG_MODE_BIT    = 1;
    localparam int          CFG_VREF_BIT    = 0;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    // input-select codes that ground the negative input
    localparam logic [2:0]  MUX_SE_LO       = 3'h3;
    localparam logic [2:0]  MUX_SE_HI       = 3'h6;
    // command codes
    localparam logic [7:0]  CMD_RESET       = 8'h06;
    localparam logic [7:0]  CMD_START       = 8'h08;
    localparam logic [7:0]  CMD_POWERDOWN   = 8'h02;
    localparam logic [7:0]  CMD_READ_DATA   = 8'h10;
    localparam logic [7:0]  CMD_READ_CONFIG = 8'h20;
    localparam logic [7:0]  CMD_WRITE_CONFIG= 8'h40;
    // start delay in oscillator half periods, conversion periods in oscillator periods
    localparam int unsigned START_HALF      = 57;
    localparam int unsigned PERIOD_20       = 51192;
    localparam int unsigned PERIOD_90       = 11532;
    localparam int unsigned PERIOD_330      = 3116;
    localparam int unsigned PERIOD_1000     = 1036;
    // result scaling shift per rate
    localparam int unsigned SHIFT_20        = 9;
    localparam int unsigned SHIFT_90        = 11;
    localparam int unsigned SHIFT_330       = 13;
    localparam int unsigned SHIFT_1000      = 15;
    localparam logic [23:0] RESULT_RESET    = 24'h000000;

    typedef enum logic [1:0] {
        ADCCC_IDLE,
        ADCCC_START_WAIT,
        ADCCC_CONVERT
    } adccc_state_t;

    typedef struct packed {
        logic [2:0] input_select;
        logic       gain_four;
        logic [1:0] rate;
        logic       conversion_mode_select;
        logic       ref_external;
    } adccc_cfg_t;

    typedef struct packed {
        adccc_cfg_t   cfg;
        adccc_state_t state;
        logic [25:0]  phase;
        logic [2:0]   half_cnt;
        logic [16:0]  timer;
        logic [17:0]  acc;
        logic [23:0]  result;
        logic         data_ready;
        logic [23:0]  host_data;
        logic         stop_req;
        logic         waitrequest;
        logic [31:0]  readdata;
        logic         mod_clk;
        logic         sample_strobe;
    } adccc_regs_t;
endpackage

// ### adccc_top.sv
// Purpose: conversion control of a 24-bit delta-sigma converter
// Assumes: modulator bitstream arrives synchronous to sys_clk
// Notes:   register access over Avalon-MM, one wait cycle per access
//          result scaling and sign clamp sit in one function
//
// Contract
// - all configuration sits in one register; six host commands are accepted.
// - single-shot does one conversion, buffers result, then returns idle.
// - continuous mode starts the next conversion right after one completes.
// - result buffer always readable, holds latest result, updated atomically.
// - three-bit input select picks positive and negative converter inputs.
// - select codes 011 to 110 tie negative input to analog ground.
// - one gain bit selects gain 1 or gain 4.
// - full scale is reference over gain; code step fixed per gain.
// - ground-referenced single-ended inputs yield only non-negative codes.
// - reference bit picks internal or external reference; internal after reset.
// - modulator clock is the 1.024 MHz oscillator divided by four.
// - filter adapts to data rate and settles within one conversion.
// - data rate and conversion time scale with oscillator frequency.
// - each conversion yields a 24-bit code proportional to input.
// - first conversion begins 28.5 oscillator periods after begin command.
// - periods 51192, 11532, 3116, 1036 oscillator periods per rate setting.
// - configuration write during a conversion aborts and restarts it.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module adccc_top
    import adccc_pkg::*;
#(
    parameter int unsigned P_OSC_HZ     = OSC_HZ,
    parameter int unsigned P_PERIOD_20  = PERIOD_20,
    parameter int unsigned P_PERIOD_90  = PERIOD_90,
    parameter int unsigned P_PERIOD_330 = PERIOD_330,
    parameter int unsigned P_PERIOD_1000= PERIOD_1000
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,

    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,

    // modulator side
    input  wire logic        modulator_bit,
    output logic             modulator_clock,
    output logic             modulator_sample,

    // analog front end controls
    output logic [2:0]       input_select,
    output logic             negative_to_analog_ground,
    output logic             gain_four,
    output logic             reference_external,
    output logic             converter_active,

    // status
    output logic             data_ready
);

    // phase step is two per oscillator period
    localparam logic [25:0] PHASE_STEP = 26'(2 * P_OSC_HZ);
    localparam logic [25:0] PHASE_WRAP = 26'(SYS_CLK_HZ);

    // registered state and its next value
    adccc_regs_t st;
    adccc_regs_t next_st;

    // rate-dependent conversion length in oscillator half periods
    function automatic logic [16:0] period_half(input logic [1:0] rate);
        // counts are doubled: the timer runs on half ticks
        case (rate)
            2'h0:    period_half = 17'(2 * P_PERIOD_20);
            2'h1:    period_half = 17'(2 * P_PERIOD_90);
            2'h2:    period_half = 17'(2 * P_PERIOD_330);
            default: period_half = 17'(2 * P_PERIOD_1000);
        endcase
    endfunction

    // boxcar scaling so every rate reaches near full 24-bit scale
    function automatic logic [23:0] scale_result(input logic [17:0] acc,
                                                 input adccc_cfg_t  cfg);
        logic signed [41:0] wide;
        logic        [5:0]  sh;
        logic               se;
        // widen first so the shift cannot overflow
        wide = 42'(signed'(acc));
        sh   = 6'(SHIFT_1000);
        se   = 1'b0;
        case (cfg.rate)
            2'h0:    sh = 6'(SHIFT_20);
            2'h1:    sh = 6'(SHIFT_90);
            2'h2:    sh = 6'(SHIFT_330);
            default: sh = 6'(SHIFT_1000);
        endcase

        // longer conversions collect more samples, so they shift less
        wide = wide <<< sh;

        // grounded negative input cannot give a negative code
        se = (cfg.input_select >= MUX_SE_LO) && (cfg.input_select <= MUX_SE_HI);
        if (se && wide < 0) begin
            wide = '0;
        end

        // saturate to the signed 24-bit range
        if (wide > 42'sh7FFFFF) begin
            scale_result = 24'h7FFFFF;
        end else if (wide < -42'sh800000) begin
            scale_result = 24'h800000;
        end else begin
            scale_result = wide[23:0];
        end
    endfunction

    // bus and oscillator helpers
    logic        bus_req;
    logic        bus_done;
    logic        osc_half_tick;
    logic [25:0] phase_sum;

    // one wait cycle: request seen with waitrequest high, done next edge
    assign bus_req  = avs_read | avs_write;
    assign bus_done = bus_req & ~st.waitrequest;

    // fractional divider gives the oscillator half-period tick
    assign phase_sum     = st.phase + PHASE_STEP;
    assign osc_half_tick = (phase_sum >= PHASE_WRAP);
    // limitation: ticks jitter by one system clock

    // next-state logic for the whole block
    always_comb begin
        logic        start_cmd;
        logic        cfg_write;
        logic        do_reset;
        logic        mod_tick;
        logic [7:0]  cmd;
        start_cmd = 1'b0;
        cfg_write = 1'b0;
        do_reset  = 1'b0;
        mod_tick  = 1'b0;

        cmd       = avs_writedata[7:0];
        next_st   = st;

        // bus handshake and read data
        // waitrequest drops for exactly one cycle per access
        next_st.waitrequest = ~(bus_req & st.waitrequest);
        if (bus_req && st.waitrequest && avs_read) begin
            case (avs_address)
                OFS_CONFIG:    next_st.readdata = {24'h000000, st.cfg};
                OFS_STATUS:    next_st.readdata = {28'h0000000, st.stop_req,
                                                   st.data_ready, st.state};
                OFS_RESULT:    next_st.readdata = {8'h00, st.result};
                OFS_HOST_DATA: next_st.readdata = {8'h00, st.host_data};
                default:       next_st.readdata = 32'h00000000;
            endcase
        end

        // oscillator phase and modulator clock division
        // four half ticks per modulator clock edge, eight per period
        next_st.phase         = osc_half_tick ? phase_sum - PHASE_WRAP : phase_sum;
        next_st.sample_strobe = 1'b0;
        if (osc_half_tick) begin
            next_st.half_cnt = st.half_cnt + 3'h1;
            if (st.half_cnt[1:0] == 2'h3) begin
                next_st.mod_clk = ~st.mod_clk;
            end
            mod_tick = (st.half_cnt == 3'h7);
        end

        // writes take effect at the completing edge
        // reads have no side effect; commands act once per access
        if (bus_done && avs_write) begin
            case (avs_address)
                OFS_CONFIG: begin
                    next_st.cfg = adccc_cfg_t'(avs_writedata[7:0]);
                    cfg_write   = 1'b1;
                end
                OFS_COMMAND: begin
                    // unknown codes are ignored
                    case (cmd)
                        CMD_RESET:     do_reset  = 1'b1;
                        CMD_START:     start_cmd = 1'b1;
                        CMD_POWERDOWN: next_st.stop_req = (st.state != ADCCC_IDLE);
                        CMD_READ_DATA: begin
                            next_st.host_data = st.result;
                            next_st.data_ready = 1'b0;
                        end
                        CMD_READ_CONFIG:  next_st.host_data = {16'h0000, st.cfg};
                        CMD_WRITE_CONFIG: begin
                            next_st.cfg = adccc_cfg_t'(avs_writedata[15:8]);
                            cfg_write   = 1'b1;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // configuration write while busy acts as a fresh begin command
        if (cfg_write && st.state != ADCCC_IDLE) begin
            start_cmd = 1'b1;
        end

        // conversion sequencer
        // idle, start delay, then convert
        case (st.state)
            // nothing to do until a begin command
            ADCCC_IDLE: begin
                next_st.stop_req = 1'b0;
            end

            // 57 half ticks, then load the conversion length
            ADCCC_START_WAIT: begin
                if (osc_half_tick) begin
                    if (st.timer == 17'h00001) begin
                        next_st.state = ADCCC_CONVERT;
                        next_st.timer = period_half(st.cfg.rate);
                        next_st.acc   = '0;
                    end else begin
                        next_st.timer = st.timer - 17'h00001;
                    end
                end
            end

            ADCCC_CONVERT: begin
                // one modulator bit per modulator period
                if (mod_tick) begin
                    next_st.sample_strobe = 1'b1;
                    next_st.acc = modulator_bit ? st.acc + 18'h00001
                                                : st.acc - 18'h00001;
                end
                if (osc_half_tick) begin
                    if (st.timer == 17'h00001) begin
                        // whole 24-bit word replaced in one edge
                        next_st.result     = scale_result(next_st.acc, st.cfg);
                        next_st.data_ready = 1'b1;
                        next_st.acc        = '0;
                        // continuous reloads unless powerdown is pending
                        if (st.cfg.conversion_mode_select && !st.stop_req) begin
                            next_st.timer = period_half(st.cfg.rate);
                        end else begin
                            next_st.state    = ADCCC_IDLE;
                            next_st.stop_req = 1'b0;
                        end
                    end else begin
                        next_st.timer = st.timer - 17'h00001;
                    end
                end
            end

            default: begin
                next_st.state = ADCCC_IDLE;
            end
        endcase

        // begin command restarts the sequence from the start delay
        // applied late so it beats a completion in the same cycle
        if (start_cmd) begin
            next_st.state    = ADCCC_START_WAIT;
            next_st.timer    = 17'(START_HALF);
            next_st.acc      = '0;
            next_st.stop_req = 1'b0;
        end

        // command reset returns every control field to its default
        // placed after the start so a reset always wins
        if (do_reset) begin
            next_st.cfg        = adccc_cfg_t'(CFG_RESET);
            next_st.state      = ADCCC_IDLE;
            next_st.timer      = '0;
            next_st.acc        = '0;
            next_st.result     = RESULT_RESET;
            next_st.data_ready = 1'b0;
            next_st.host_data  = RESULT_RESET;
            next_st.stop_req   = 1'b0;
        end
    end

    // single state register; reset is synchronous
    // bus and phase fields return to idle too
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st.cfg           <= adccc_cfg_t'(CFG_RESET);
            st.state         <= ADCCC_IDLE;
            st.phase         <= '0;
            st.half_cnt      <= '0;
            st.timer         <= '0;
            st.acc           <= '0;
            st.result        <= RESULT_RESET;
            st.data_ready    <= 1'b0;
            st.host_data     <= RESULT_RESET;
            st.stop_req      <= 1'b0;
            // bus idles with waitrequest high
            st.waitrequest   <= 1'b1;
            st.readdata      <= 32'h00000000;
            st.mod_clk       <= 1'b0;
            st.sample_strobe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // front end controls come straight from the configuration flops
    // bus outputs are registered fields of the state
    assign input_select              = st.cfg.input_select;
    assign gain_four                 = st.cfg.gain_four;
    assign reference_external        = st.cfg.ref_external;
    assign avs_readdata              = st.readdata;
    assign avs_waitrequest           = st.waitrequest;
    assign modulator_clock           = st.mod_clk;
    assign modulator_sample          = st.sample_strobe;
    assign data_ready                = st.data_ready;

    // grounding flag registered so the pin has no decode glitch
    // computed from next_st so it changes with the select pins
    logic neg_gnd;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            neg_gnd <= 1'b0;
        end else begin
            neg_gnd <= (next_st.cfg.input_select >= MUX_SE_LO) &&
                       (next_st.cfg.input_select <= MUX_SE_HI);
        end
    end
    assign negative_to_analog_ground = neg_gnd;

    // busy flag registered so the pin comes straight from a flop
    logic busy_flag;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= (next_st.state != ADCCC_IDLE);
        end
    end
    assign converter_active = busy_flag;

endmodule

// ### adccc_sva.sv
// Purpose: port assertions for the converter control block
// Assumes: one clock, rst_n synchronous active low
// Notes:   bind statement follows the module
`timescale 1ns/10ps
module adccc_sva
    import adccc_pkg::*;
#(
    parameter int unsigned P_OSC_HZ      = OSC_HZ,
    parameter int unsigned P_PERIOD_1000 = PERIOD_1000
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // converter side
    input wire logic        modulator_clock,
    input wire logic        modulator_sample,
    input wire logic [2:0]  input_select,
    input wire logic        negative_to_analog_ground,
    input wire logic        gain_four,
    input wire logic        reference_external,
    input wire logic        converter_active,
    input wire logic        data_ready
);
    // half a modulator period in cycles, rounded down; this loosens CMIN but tightens the mod_fast_a bound
    localparam int HALF = 2 * (SYS_CLK_HZ / 1000) / (P_OSC_HZ / 1000);
    localparam int CMIN = (57 + 2 * P_PERIOD_1000) * HALF / 4 - 3;
    logic        mod_prev;
    logic [7:0]  mod_cnt;
    logic [31:0] act_cnt;
    wire logic   cmd_ok = avs_write && !avs_waitrequest && avs_address == OFS_COMMAND;
    // cycles since the modulator clock moved, and length of each busy stretch
    always_ff @(posedge sys_clk) begin
        mod_prev <= modulator_clock;
        mod_cnt  <= (!converter_active || modulator_clock != mod_prev) ? 8'h00 : mod_cnt + 8'h01;
        act_cnt  <= converter_active ? act_cnt + 32'h1 : 32'h0;
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wait_one_a: assert property (avs_waitrequest && (avs_read || avs_write)
        |=> !avs_waitrequest) else $error("access not answered");
    wait_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    ground_switch_a: assert property (negative_to_analog_ground ==
        (input_select >= MUX_SE_LO && input_select <= MUX_SE_HI)) else $error("ground switch");
    cfg_follow_a: assert property (!$stable({input_select, gain_four, reference_external})
        |-> $past(avs_write && !avs_waitrequest)) else $error("settings moved alone");
    start_go_a: assert property (cmd_ok && avs_writedata[7:0] == CMD_START
        |-> ##[1:2] converter_active) else $error("start ignored");
    ready_clear_a: assert property (cmd_ok && avs_writedata[7:0] == CMD_READ_DATA
        && !converter_active |=> !data_ready) else $error("ready not cleared");
    mod_fast_a: assert property (converter_active |-> mod_cnt <= HALF + 1)
        else $error("modulator clock too slow");
    conv_min_a: assert property ($fell(converter_active) |-> act_cnt >= CMIN)
        else $error("conversion too short");
    sample_pulse_a: assert property (modulator_sample |=> !modulator_sample)
        else $error("sample pulse too long");
endmodule
bind adccc_top adccc_sva #(.P_OSC_HZ(P_OSC_HZ), .P_PERIOD_1000(P_PERIOD_1000)) u_adccc_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .modulator_clock(modulator_clock), .modulator_sample(modulator_sample),
    .input_select(input_select), .negative_to_analog_ground(negative_to_analog_ground),
    .gain_four(gain_four), .reference_external(reference_external),
    .converter_active(converter_active), .data_ready(data_ready));

// ### adccc_mod_src.sv
// Purpose: modulator bitstream source facing the control block
// Assumes: bits advance after each sample pulse
// Notes:   pattern 0 zeros, 1 ones, 2 alternating
`timescale 1ns/10ps
module adccc_mod_src (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // pattern and converter side
    input  wire logic [1:0] pattern,
    input  wire logic       modulator_sample,
    output logic            modulator_bit
);
    // move only after a sample so the taken bit never races the tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modulator_bit <= 1'b0;
        end else if (pattern != 2'h2) begin
            modulator_bit <= pattern[0];
        end else if (modulator_sample) begin
            modulator_bit <= ~modulator_bit;
        end
    end
endmodule

// ### tb_adccc_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: oscillator sped up to 6 MHz, periods 50/40/30/20
// Notes:   settings table first, conversions hand written
`timescale 1ns/10ps
module tb_adccc_top
    import adccc_pkg::*;
;
    localparam int         PER [4]  = '{50, 40, 30, 20};
    localparam logic [4:0] RADR [4] = '{OFS_CONFIG, OFS_STATUS, OFS_RESULT, 5'h18};
    // config byte beside select, ground, gain and reference pins
    localparam logic [13:0] ROWS [8] = '{{8'h00, 6'h00}, {8'h30, 6'h0A}, {8'h41, 6'h11},
        {8'h71, 6'h1F}, {8'h80, 6'h24}, {8'hB0, 6'h2E}, {8'hC1, 6'h35}, {8'hF1, 6'h3B}};
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [1:0]  pattern = 2'h1;
    logic [31:0] avs_readdata, rd;
    logic [2:0]  input_select;
    logic        avs_waitrequest, modulator_bit, modulator_clock, modulator_sample;
    logic        negative_to_analog_ground, gain_four, reference_external;
    logic        converter_active, data_ready;
    int          mismatches = 0, total_checks = 0, n = 0;
    wire logic [5:0] pins = {input_select, negative_to_analog_ground, gain_four, reference_external};
    adccc_top #(.P_OSC_HZ(6_000_000), .P_PERIOD_20(50), .P_PERIOD_90(40), .P_PERIOD_330(30),
        .P_PERIOD_1000(20)) u_adccc_top (.sys_clk(sys_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .modulator_bit(modulator_bit),
        .modulator_clock(modulator_clock), .modulator_sample(modulator_sample),
        .input_select(input_select), .negative_to_analog_ground(negative_to_analog_ground),
        .gain_four(gain_four), .reference_external(reference_external),
        .converter_active(converter_active), .data_ready(data_ready));
    adccc_mod_src u_adccc_mod_src (.sys_clk(sys_clk), .rst_n(rst_n), .pattern(pattern),
        .modulator_sample(modulator_sample), .modulator_bit(modulator_bit));
    // 40 ns period
    always #20 sys_clk = ~sys_clk;
    // cycles for h oscillator half periods at 6 MHz
    function automatic logic [31:0] near(input int c, input int h);
        return {31'h0, c > h * 25 / 12 - 6 && c < h * 25 / 12 + 6};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one access, held until waitrequest is seen low, then one idle cycle
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 100) begin
            chk(32'h0, 32'h1, "bus timeout");
            results();
        end
        @(posedge sys_clk);
    endtask
    // bounded wait for busy (sel 0) or ready (sel 1) to reach lvl
    task automatic hold(input logic sel, input logic lvl, output int c);
        c = 0;
        while ((sel ? data_ready : converter_active) !== lvl && c < 5000) begin
            @(posedge sys_clk);
            c++;
        end
        if (c >= 5000) begin
            chk(32'h0, 32'h1, "wait timeout");
            results();
        end
    endtask
    task automatic conv(input logic [7:0] cfg, output int len);
        bus(1'b1, OFS_CONFIG, {24'h0, cfg});
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_START});
        hold(1'b0, 1'b1, len);
        hold(1'b0, 1'b0, len);
        chk({31'h0, data_ready}, 32'h1, "ready after single");
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DATA});
        chk({31'h0, data_ready}, 32'h0, "ready cleared");
        bus(1'b0, OFS_HOST_DATA, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk({30'h0, reference_external, data_ready}, 32'h0, "pins after reset");
        bus(1'b1, OFS_RESULT, 32'hFFFFFFFF);
        bus(1'b1, 5'h18, 32'hFFFFFFFF);
        foreach (RADR[i]) begin
            bus(1'b0, RADR[i], 32'h0);
            chk(rd, 32'h0, "register after reset");
        end
        $display("test reset done");
        foreach (ROWS[i]) begin
            if (i % 2 == 1) begin
                bus(1'b1, OFS_COMMAND, {16'h0, ROWS[i][13:6], CMD_WRITE_CONFIG});
            end else begin
                bus(1'b1, OFS_CONFIG, {24'h0, ROWS[i][13:6]});
            end
            chk({26'h0, pins}, {26'h0, ROWS[i][5:0]}, "front end pins");
            bus(1'b0, OFS_CONFIG, 32'h0);
            chk(rd, {24'h0, ROWS[i][13:6]}, "config readback");
        end
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_CONFIG});
        bus(1'b0, OFS_HOST_DATA, 32'h0);
        chk(rd, 32'h000000F1, "config copy");
        bus(1'b1, OFS_CONFIG, 32'h0);
        repeat (625) @(posedge sys_clk);
        $display("test settings done");
        for (int r = 0; r < 4; r++) begin
            conv({4'h0, 2'(r), 2'h0}, n);
            chk(near(n + 1, 57 + 2 * PER[r]), 32'h1, "single length");
            chk({31'h0, rd[23] == 1'b0 && rd != 32'h0}, 32'h1, "positive code");
        end
        pattern <= 2'h0;
        conv(8'h6C, n);
        chk(rd, 32'h0, "grounded code");
        $display("test single done");
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_START});
        hold(1'b0, 1'b1, n);
        repeat (100) @(posedge sys_clk);
        bus(1'b1, OFS_CONFIG, 32'h0C);
        hold(1'b0, 1'b0, n);
        chk({31'h0, n > 97 * 25 / 12 - 8}, 32'h1, "restart length");
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DATA});
        $display("test restart done");
        pattern <= 2'h2;
        bus(1'b1, OFS_CONFIG, 32'h0E);
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_START});
        hold(1'b1, 1'b1, n);
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DATA});
        hold(1'b1, 1'b1, n);
        chk(near(n + 4, 40), 32'h1, "continuous period");
        chk({31'h0, converter_active}, 32'h1, "still converting");
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DATA});
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_POWERDOWN});
        hold(1'b0, 1'b0, n);
        chk({31'h0, data_ready && n < 90}, 32'h1, "stop after last");
        $display("test continuous done");
        bus(1'b1, OFS_CONFIG, 32'hF1);
        bus(1'b1, OFS_COMMAND, {24'h0, CMD_RESET});
        bus(1'b0, OFS_CONFIG, 32'h0);
        chk(rd, 32'h0, "config after reset command");
        $display("test command reset done");
        results();
    end
endmodule
